// >>> tdp_pkg.sv
// Notes on behaviour
// - gain strap high gives 6, low 12
// - gain only changes the numeric threshold
// - levels are 16 bits wide; the threshold sum has a 17th bit for saturation
// - reference slews slowly, only without detection
// - threshold and hysteresis follow the reference
// - reference frozen while detection is active
// - reference falls faster than it rises
// - threshold is an offset above reference
// - release needs 17 percent hysteresis dropout
// - on-time limit exceeded forces full recalibration
// - limits of 10 s, 60 s or none
// - three exceeding samples activate the output
// - any miss clears the integrator at once
// - recalibration on demand only at power-up
// - straps are sampled only at power-up
// - option straps pick output mode and limit
// - dc mode drives low until end or timeout
// - toggle mode flips, timeout keeps the state
// - 300 us high impedance after every sample
package tdp_pkg;
    // arithmetic width and threshold figures
    localparam int DATA_W = 16;
    localparam logic [15:0] THR_HIGH = 16'h0006;
    localparam logic [15:0] THR_LOW = 16'h000C;
    localparam logic [15:0] HYST_PCT = 16'h0011;
    localparam logic [15:0] PCT_DIV = 16'h0064;
    localparam logic [1:0] INTEG_LAST = 2'h2;
    // timing, all derived from the 20 MHz clock
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int HEALTH_US = 300;
    localparam int HEALTH_CYC = (CLK_HZ / 1_000_000) * HEALTH_US;
    localparam int LIMIT_SHORT_S = 10;
    localparam int LIMIT_LONG_S = 60;
    localparam int MS_PER_S = 1000;
    localparam logic [15:0] LIMIT_SHORT_MS = 16'(LIMIT_SHORT_S * MS_PER_S);
    localparam logic [15:0] LIMIT_LONG_MS = 16'(LIMIT_LONG_S * MS_PER_S);
    localparam logic [2:0] CFG_WAIT = 3'h4;
    localparam int STRAP_W = 3;
    // register byte offsets
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_REF = 4'h4;
    localparam logic [3:0] ADR_SAMPLE = 4'h8;
    localparam logic [3:0] ADR_DRIFT = 4'hC;
    // drift control fields and reset values
    localparam int RISE_LSB = 0;
    localparam int FALL_LSB = 8;
    localparam logic [7:0] RISE_DIV_RST = 8'h10;
    localparam logic [7:0] FALL_DIV_RST = 8'h02;
    // status field positions
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_TOGGLE_BIT = 1;
    localparam int ST_INTEG_LSB = 2;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_GAIN_BIT = 6;
    localparam int ST_REFOK_BIT = 7;
    typedef enum logic [1:0] {
        MODE_TOGGLE = 2'b00,
        MODE_DC_INF = 2'b01,
        MODE_DC_60 = 2'b10,
        MODE_DC_10 = 2'b11
    } tdp_mode_type;
    typedef enum logic [1:0] {
        ST_CFG = 2'b00,
        ST_CAL = 2'b01,
        ST_IDLE = 2'b10,
        ST_DET = 2'b11
    } tdp_state_type;
endpackage

// >>> tdp_pin_sync.sv
`timescale 1ns/10ps
module tdp_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [tdp_pkg::STRAP_W-1:0] pin_i,
    output logic [tdp_pkg::STRAP_W-1:0] level_o
);
    genvar g;
    generate
        for (g = 0; g < tdp_pkg::STRAP_W; g++) begin : g_bit
            logic s1_r, s2_r, s3_r, lvl_r;
            // first stage feeds only the second; level moves on agreement
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    lvl_r <= 1'b0;
                end else begin
                    s1_r <= pin_i[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        lvl_r <= s3_r;
                    end
                end
            end
            assign level_o[g] = lvl_r;
        end
    endgenerate
endmodule

// >>> tdp_on_timer.sv
`timescale 1ns/10ps
module tdp_on_timer #(
    parameter int TICK_CYCLES = tdp_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic infinite_i,
    input wire logic [15:0] limit_i,
    output logic expired_o
);
    logic [31:0] pre_r;
    logic [15:0] ms_r;
    logic done_r;
    logic exp_r;

    // millisecond prescaler and on-time count, cleared when run drops
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pre_r <= 32'h00000000;
            ms_r <= 16'h0000;
            done_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            exp_r <= 1'b0;
            if (pre_r == 32'(TICK_CYCLES - 1)) begin
                pre_r <= 32'h00000000;
                if (ms_r != limit_i) begin
                    ms_r <= ms_r + 16'h0001;
                end
            end else begin
                pre_r <= pre_r + 32'h00000001;
            end
            // one pulse per detection; none at all when unlimited
            if (!done_r && !infinite_i && ms_r == limit_i) begin
                done_r <= 1'b1;
                exp_r <= 1'b1;
            end
        end
    end
    assign expired_o = exp_r;
endmodule

// >>> tdp_touch_detect.sv
`timescale 1ns/10ps
module tdp_touch_detect #(
    parameter int TICK_CYCLES = tdp_pkg::TICK_CYC,
    parameter int HEALTH_CYCLES = tdp_pkg::HEALTH_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] sample_i,
    input wire logic sample_valid_i,
    input wire logic gain_strap_i,
    input wire logic option_strap_a_i,
    input wire logic option_strap_b_i,
    output logic detect_out_o,
    output logic detect_oe_o,
    output logic detect_o
);
    tdp_pkg::tdp_state_type state_r;
    tdp_pkg::tdp_mode_type mode_r;
    logic [2:0] straps;
    logic [2:0] cfg_cnt_r;
    logic gain_r;
    logic [15:0] thr_r;
    logic [15:0] thr_sel;
    logic [15:0] hyst_r;
    logic [15:0] ref_r;
    logic [15:0] last_r;
    logic [1:0] integ_r;
    logic toggle_r;
    logic [7:0] rise_div_r;
    logic [7:0] fall_div_r;
    logic [7:0] rise_cnt_r;
    logic [7:0] fall_cnt_r;
    logic [31:0] health_r;
    logic [31:0] health_nxt;
    logic out_r;
    logic oe_r;
    logic det_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [16:0] thr_sum;
    logic [15:0] thr_level;
    logic [15:0] rel_level;
    logic above;
    logic below_rel;
    logic limit_inf;
    logic [15:0] limit_ms;
    logic expired;
    logic smp;
    logic [31:0] status;
    logic [31:0] mult;

    // straps come from pins, so they cross into the clock domain
    tdp_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({gain_strap_i, option_strap_a_i, option_strap_b_i}),
        .level_o(straps)
    );

    // limit chosen by the latched option mode
    always_comb begin
        limit_inf = 1'b0;
        limit_ms = tdp_pkg::LIMIT_SHORT_MS;
        case (mode_r)
            tdp_pkg::MODE_DC_60: limit_ms = tdp_pkg::LIMIT_LONG_MS;
            tdp_pkg::MODE_DC_INF: limit_inf = 1'b1;
            default: limit_ms = tdp_pkg::LIMIT_SHORT_MS;
        endcase
    end

    // on timer runs only while in the detect state
    tdp_on_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(state_r == tdp_pkg::ST_DET),
        .infinite_i(limit_inf),
        .limit_i(limit_ms),
        .expired_o(expired)
    );

    // levels are offsets from the reference, saturated at full scale
    assign thr_sum = {1'b0, ref_r} + {1'b0, thr_r};
    assign thr_level = thr_sum[16] ? 16'hFFFF : thr_sum[15:0];
    assign rel_level = thr_level - hyst_r;
    assign above = sample_i > thr_level;
    assign below_rel = sample_i < rel_level;
    assign smp = sample_valid_i && state_r != tdp_pkg::ST_CFG;
    // hysteresis from the threshold being latched, not the stale one
    assign thr_sel = straps[2] ? tdp_pkg::THR_HIGH : tdp_pkg::THR_LOW;
    assign mult = {16'h0000, thr_sel} * {16'h0000, tdp_pkg::HYST_PCT};

    // strap capture happens once, a few cycles after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_cnt_r <= 3'h0;
            mode_r <= tdp_pkg::MODE_TOGGLE;
            gain_r <= 1'b0;
            thr_r <= tdp_pkg::THR_LOW;
            hyst_r <= 16'h0000;
        end else if (state_r == tdp_pkg::ST_CFG) begin
            cfg_cnt_r <= cfg_cnt_r + 3'h1;
            gain_r <= straps[2];
            mode_r <= tdp_pkg::tdp_mode_type'(straps[1:0]);
            thr_r <= thr_sel;
            // 17 percent of the offset, truncated to whole counts
            hyst_r <= 16'(mult / 32'(tdp_pkg::PCT_DIV));
        end
    end

    // main sequence: configure, seed reference, idle, detect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= tdp_pkg::ST_CFG;
            integ_r <= 2'h0;
        end else begin
            case (state_r)
                tdp_pkg::ST_CFG: begin
                    if (cfg_cnt_r == tdp_pkg::CFG_WAIT) begin
                        state_r <= tdp_pkg::ST_CAL;
                    end
                end
                tdp_pkg::ST_CAL: begin
                    integ_r <= 2'h0;
                    if (smp) begin
                        state_r <= tdp_pkg::ST_IDLE;
                    end
                end
                tdp_pkg::ST_IDLE: begin
                    if (smp && above) begin
                        if (integ_r == tdp_pkg::INTEG_LAST) begin
                            integ_r <= 2'h0;
                            state_r <= tdp_pkg::ST_DET;
                        end else begin
                            integ_r <= integ_r + 2'h1;
                        end
                    end else if (smp) begin
                        integ_r <= 2'h0;
                    end
                end
                tdp_pkg::ST_DET: begin
                    if (expired) begin
                        state_r <= tdp_pkg::ST_CAL;
                    end else if (smp && below_rel) begin
                        state_r <= tdp_pkg::ST_IDLE;
                    end
                end
                default: state_r <= tdp_pkg::ST_CFG;
            endcase
        end
    end

    // reference: seeded on recalibration, slewed by one count per step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_r <= 16'h0000;
            rise_cnt_r <= 8'h00;
            fall_cnt_r <= 8'h00;
        end else if (state_r == tdp_pkg::ST_CAL) begin
            rise_cnt_r <= 8'h00;
            fall_cnt_r <= 8'h00;
            if (smp) begin
                ref_r <= sample_i;
            end
        end else if (state_r == tdp_pkg::ST_IDLE && smp && !above) begin
            // frozen in detect so a present finger never gets absorbed
            if (sample_i > ref_r) begin
                fall_cnt_r <= 8'h00;
                if (rise_cnt_r >= rise_div_r) begin
                    rise_cnt_r <= 8'h00;
                    ref_r <= ref_r + 16'h0001;
                end else begin
                    rise_cnt_r <= rise_cnt_r + 8'h01;
                end
            end else if (sample_i < ref_r) begin
                rise_cnt_r <= 8'h00;
                if (fall_cnt_r >= fall_div_r) begin
                    fall_cnt_r <= 8'h00;
                    ref_r <= ref_r - 16'h0001;
                end else begin
                    fall_cnt_r <= fall_cnt_r + 8'h01;
                end
            end
        end
    end

    // toggle state flips on each new detection, kept over timeouts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_r <= 1'b0;
        end else if (mode_r == tdp_pkg::MODE_TOGGLE
                     && state_r == tdp_pkg::ST_IDLE && smp && above
                     && integ_r == tdp_pkg::INTEG_LAST) begin
            toggle_r <= !toggle_r;
        end
    end

    // health window restarts on each sample
    always_comb begin
        health_nxt = health_r;
        if (smp) begin
            health_nxt = 32'(HEALTH_CYCLES);
        end else if (health_r != 32'h00000000) begin
            health_nxt = health_r - 32'h00000001;
        end
    end

    // pin is active low; released while the health window is open
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            health_r <= 32'h00000000;
            out_r <= 1'b1;
            oe_r <= 1'b1;
            det_r <= 1'b0;
        end else begin
            health_r <= health_nxt;
            oe_r <= (health_nxt == 32'h00000000);
            det_r <= (state_r == tdp_pkg::ST_DET);
            if (mode_r == tdp_pkg::MODE_TOGGLE) begin
                out_r <= !toggle_r;
            end else begin
                out_r <= !(state_r == tdp_pkg::ST_DET);
            end
        end
    end

    // last sample kept for software to watch the raw level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_r <= 16'h0000;
        end else if (smp) begin
            last_r <= sample_i;
        end
    end

    assign status = {24'h000000,
                     state_r != tdp_pkg::ST_CFG
                         && state_r != tdp_pkg::ST_CAL,
                     gain_r, mode_r, integ_r, toggle_r,
                     state_r == tdp_pkg::ST_DET};

    // single-cycle wishbone slave; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
            dat_r <= 32'h00000000;
            case (wb_adr_i)
                tdp_pkg::ADR_STATUS: dat_r <= status;
                tdp_pkg::ADR_REF: dat_r <= {16'h0000, ref_r};
                tdp_pkg::ADR_SAMPLE: dat_r <= {16'h0000, last_r};
                tdp_pkg::ADR_DRIFT: dat_r <= {16'h0000, fall_div_r,
                                              rise_div_r};
                default: dat_r <= 32'h00000000;
            endcase
        end
    end

    // drift rate dividers, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_div_r <= tdp_pkg::RISE_DIV_RST;
            fall_div_r <= tdp_pkg::FALL_DIV_RST;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_r
                     && wb_adr_i == tdp_pkg::ADR_DRIFT) begin
            if (wb_sel_i[0]) begin
                rise_div_r <= wb_dat_i[tdp_pkg::RISE_LSB +: 8];
            end
            if (wb_sel_i[1]) begin
                fall_div_r <= wb_dat_i[tdp_pkg::FALL_LSB +: 8];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign detect_out_o = out_r;
    assign detect_oe_o = oe_r;
    assign detect_o = det_r;

    // checks on the detection path
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    thr_select_a: assert property (
        state_r != tdp_pkg::ST_CFG |-> thr_r ==
            (gain_r ? tdp_pkg::THR_HIGH : tdp_pkg::THR_LOW))
        else $error("threshold does not match gain strap");

    strap_hold_a: assert property (
        state_r != tdp_pkg::ST_CFG |=> $stable(mode_r) && $stable(thr_r))
        else $error("strap setting changed after power-up");

    ref_freeze_a: assert property (
        state_r == tdp_pkg::ST_DET ##1 state_r == tdp_pkg::ST_DET
            |-> $stable(ref_r))
        else $error("reference moved during detection");

    ref_slew_a: assert property (
        $past(state_r) == tdp_pkg::ST_IDLE && $changed(ref_r) |->
            (ref_r == $past(ref_r) + 16'h0001
             || ref_r == $past(ref_r) - 16'h0001))
        else $error("reference stepped by more than one count");

    integ_clear_a: assert property (
        state_r == tdp_pkg::ST_IDLE && smp && !above |=> integ_r == 2'h0)
        else $error("integrator not cleared on a miss");

    det_entry_a: assert property (
        $rose(state_r == tdp_pkg::ST_DET) |->
            $past(integ_r) == tdp_pkg::INTEG_LAST && $past(above))
        else $error("detection without three samples");

    release_a: assert property (
        state_r == tdp_pkg::ST_DET && smp && !below_rel && !expired
            |=> state_r == tdp_pkg::ST_DET)
        else $error("released inside hysteresis band");

    recal_a: assert property (
        state_r == tdp_pkg::ST_DET && expired |=> state_r == tdp_pkg::ST_CAL)
        else $error("timeout did not recalibrate");

    dc_out_a: assert property (
        mode_r != tdp_pkg::MODE_TOGGLE && state_r == tdp_pkg::ST_DET
            |=> !detect_out_o ##1 1)
        else $error("dc output not low during detection");

    toggle_keep_a: assert property (
        mode_r == tdp_pkg::MODE_TOGGLE && expired
            |=> $stable(toggle_r) && $stable(detect_out_o))
        else $error("timeout changed toggle state");

    health_start_a: assert property (
        smp |=> !detect_oe_o [*2])
        else $error("no health release after sample");
endmodule

// >>> tdp_host_model.sv
`timescale 1ns/10ps
// host side of the detect pin: pull-down load, counts health pulses
module tdp_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic detect_out_i,
    input wire logic detect_oe_i,
    output logic pin_o,
    output logic [15:0] beats_o
);
    logic oe_r;

    // a released pin falls to the pull-down, so pulses show when idle
    assign pin_o = detect_oe_i ? detect_out_i : 1'b0;

    // one health pulse is one release of the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_r <= 1'b1;
            beats_o <= 16'h0000;
        end else begin
            oe_r <= detect_oe_i;
            if (oe_r && !detect_oe_i) begin
                beats_o <= beats_o + 16'h0001;
            end
        end
    end
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    // short tick so one 10 s limit is 20000 cycles
    localparam int TICK = 2;
    localparam int HLTH = 20;
    localparam int LIM = 10000 * TICK + 2000;
    logic clk_i, rst_i, cyc, stb, we, valid, gain, opt_a, opt_b;
    logic ack, det_out, det_oe, det, pin;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, dat_o;
    logic [15:0] smp, beats, b0, base, thr, hy;
    tdp_pkg::tdp_mode_type md;
    int errors, samples_checked, cycles, k;

    tdp_touch_detect #(.TICK_CYCLES(TICK), .HEALTH_CYCLES(HLTH)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .sample_i(smp),
        .sample_valid_i(valid), .gain_strap_i(gain),
        .option_strap_a_i(opt_a), .option_strap_b_i(opt_b),
        .detect_out_o(det_out), .detect_oe_o(det_oe), .detect_o(det));

    tdp_host_model host (.clk_i(clk_i), .rst_i(rst_i),
        .detect_out_i(det_out), .detect_oe_i(det_oe), .pin_o(pin),
        .beats_o(beats));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang is cut short well past the longest expected run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            end_of_test();
        end
    end

    // classic single cycle, held until ack is sampled high
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        if (ack !== 1'b1) begin
            errors++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        check(nm, rdat, e);
    endtask

    // each sample is a one-cycle pulse, outputs settled two edges later
    task send(input logic [15:0] v, input int reps);
        repeat (reps) begin
            @(posedge clk_i);
            smp <= v;
            valid <= 1'b1;
            @(posedge clk_i);
            valid <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask

    // power cycle is the only way to take new straps; a timeout also recalibrates
    task power_up(input logic g, input logic a, input logic b);
        @(posedge clk_i);
        rst_i <= 1'b1;
        gain <= g;
        opt_a <= a;
        opt_b <= b;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        check("idle pins", {29'h0, det_out, det_oe, det}, 32'h6);
    endtask

    // release only once below threshold minus the hysteresis margin
    task rel_chk(input int reps);
        send(base + thr - hy, reps);
        check("held", det, 1'b1);
        send(base + thr - hy - 16'h0001, 1);
        check("released", det, 1'b0);
    endtask

    task hold;
        k = 0;
        while (det === 1'b1 && k < LIM) begin
            @(posedge clk_i);
            k++;
        end
        repeat (2) @(posedge clk_i);
    endtask

    task setup(input logic g, input logic [15:0] b);
        base = b;
        thr = g ? tdp_pkg::THR_HIGH : tdp_pkg::THR_LOW;
        hy = thr * tdp_pkg::HYST_PCT / tdp_pkg::PCT_DIV;
        send(base, 1);
    endtask

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, valid, gain, opt_a, opt_b} = 7'h00;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        smp = 16'h0000;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        // every option strap setting lands in the mode field
        for (int i = 0; i < 4; i++) begin
            md = tdp_pkg::tdp_mode_type'(i[1:0]);
            power_up(i[0], md[1], md[0]);
            rd_chk("status", tdp_pkg::ADR_STATUS, {25'h0, i[0], md, 4'h0});
        end
        // high gain, dc output with the short limit
        power_up(1'b1, 1'b1, 1'b1);
        rd_chk("drift rst", tdp_pkg::ADR_DRIFT, 32'h0000_0210);
        wb(1'b1, 4'h6, 32'hFFFF_FFFF);
        rd_chk("unmapped", 4'h6, 32'h0000_0000);
        setup(1'b1, 16'h03E8);
        wb(1'b1, tdp_pkg::ADR_REF, 32'h0000_FFFF);
        rd_chk("ref seed", tdp_pkg::ADR_REF, {16'h0, base});
        send(base + thr, 3);
        check("at level", det, 1'b0);
        send(base + thr + 16'h0001, 2);
        send(base, 1);
        send(base + thr + 16'h0001, 2);
        check("integ clear", det, 1'b0);
        send(base + thr + 16'h0001, 1);
        check("detect", det, 1'b1);
        check("dc low", det_out, 1'b0);
        gain <= 1'b0;
        opt_a <= 1'b0;
        opt_b <= 1'b0;
        rel_chk(20);
        rd_chk("ref frozen", tdp_pkg::ADR_REF, {16'h0, base});
        wb(1'b0, tdp_pkg::ADR_STATUS, 32'h0000_0000);
        check("straps", rdat[6:4], 3'h7);
        // one health pulse of the set length after a lone sample
        repeat (30) @(posedge clk_i);
        b0 = beats;
        send(base, 1);
        check("health pin", pin, 1'b0);
        // two released cycles seen; the loop counts its exit edge too
        k = 1;
        while (det_oe === 1'b0 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        check("health len", k, HLTH);
        check("health cnt", beats, b0 + 16'h0001);
        // falling drift steps after three samples, rising not yet
        send(base - 16'h000A, 2);
        rd_chk("ref fall2", tdp_pkg::ADR_REF, {16'h0, base});
        send(base - 16'h000A, 1);
        rd_chk("ref fall3", tdp_pkg::ADR_REF, {16'h0, base - 16'h0001});
        send(base - 16'h0001 + thr, 3);
        rd_chk("ref rise3", tdp_pkg::ADR_REF, {16'h0, base - 16'h0001});
        send(base + thr, 3);
        check("moved level", det, 1'b1);
        hold();
        check("dc timeout", det, 1'b0);
        check("not early", k >= 10000 * TICK - 8, 1'b1);
        check("dc freed", det_out, 1'b1);
        check("pin idle", pin, 1'b1);
        send(base + 16'h000A, 1);
        rd_chk("reseed", tdp_pkg::ADR_REF, {16'h0, base + 16'h000A});
        // low gain, toggle output
        power_up(1'b0, 1'b0, 1'b0);
        setup(1'b0, 16'h07D0);
        send(base + thr, 3);
        check("low level", det, 1'b0);
        send(base + thr + 16'h0001, 3);
        check("toggle on", det_out, 1'b0);
        hold();
        check("tg timeout", det, 1'b0);
        check("tg kept", det_out, 1'b0);
        send(base, 1);
        send(base + thr + 16'h0001, 3);
        check("toggle off", det_out, 1'b1);
        rel_chk(1);
        check("tg stays", det_out, 1'b1);
        // dc output with no limit keeps a long detection
        power_up(1'b1, 1'b0, 1'b1);
        setup(1'b1, 16'h03E8);
        send(base + thr + 16'h0001, 3);
        hold();
        check("no limit", det, 1'b1);
        check("still low", det_out, 1'b0);
        check("pin low", pin, 1'b0);
        // dc output with the long limit outlives the short one
        power_up(1'b1, 1'b1, 1'b0);
        setup(1'b1, 16'h03E8);
        send(base + thr + 16'h0001, 3);
        repeat (10000 * TICK + 100) @(posedge clk_i);
        check("long limit", det, 1'b1);
        end_of_test();
    end
endmodule
